/* File: src/pee_consts.svh */
`ifndef PEE_CONSTS_SVH
`define PEE_CONSTS_SVH

// ==========================================
// Geometry
`define PEE_ADDR_W 11
`define PEE_DATA_W 8
`define PEE_POLL_BIT 7
`define PEE_ID_BASE 11'h7e0

// ==========================================
// Timing, printed figures then cycle counts at 100 MHz
`define PEE_CLK_NS 10
`define PEE_SETUP_NS 50
`define PEE_PULSE_NS 100
`define PEE_HOLD_NS 50
`define PEE_ACC_NS 150
`define PEE_FLOAT_NS 50
`define PEE_HV_SETUP_NS 1000
`define PEE_WC_STD_US 1000
`define PEE_WC_FAST_US 200
`define PEE_LOCKOUT_US 5000
`define PEE_ERASE_US 10000
`define PEE_SETUP_CYC ((`PEE_SETUP_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_PULSE_CYC ((`PEE_PULSE_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_HOLD_CYC ((`PEE_HOLD_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_ACC_CYC ((`PEE_ACC_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS + 1)
`define PEE_FLOAT_CYC ((`PEE_FLOAT_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_HV_CYC ((`PEE_HV_SETUP_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_WC_STD_CYC ((`PEE_WC_STD_US * 1000) / `PEE_CLK_NS)
`define PEE_WC_FAST_CYC ((`PEE_WC_FAST_US * 1000) / `PEE_CLK_NS)
`define PEE_LOCKOUT_CYC ((`PEE_LOCKOUT_US * 1000 + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_ERASE_CYC ((`PEE_ERASE_US * 1000 + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_POLL_GAP_CYC 4

`endif

/* File: src/pee_pkg.sv */
package pee_pkg;
  // ==========================================
  // Command kinds
  typedef enum logic [1:0] {
    PEE_CMD_READ = 2'h0,
    PEE_CMD_WRITE = 2'h1,
    PEE_CMD_CLEAR = 2'h2
  } pee_cmd_t;

  // Request from the user side
  typedef struct packed {
    pee_cmd_t cmd;
    logic id_area;
    logic [10:0] addr;
    logic [7:0] data;
  } pee_req_t;

  // Pins toward the memory, all strobes active low
  typedef struct packed {
    logic [10:0] addr_bus;
    logic id_area_hv_select;
    logic oe_hv;
    logic cs_n;
    logic oe_n;
    logic we_n;
  } pee_pins_t;

  // Answer to the user side
  typedef struct packed {
    logic [7:0] data;
    logic timeout;
  } pee_rsp_t;
endpackage : pee_pkg

/* File: src/pee_timer.sv */
`timescale 1ns/1ps
`include "pee_consts.svh"
// ==========================================
// Down counter; done is a one-cycle pulse when a loaded count expires
module pee_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Control
  input wire logic load,
  input wire logic [20:0] count,
  // Status
  output logic done,
  output logic running
);
  logic [20:0] cnt;
  logic [20:0] next_cnt;
  logic next_done;

  // Count down to one, then pulse
  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (load) begin
      next_cnt = count;
    end else if (cnt == 21'h000001) begin
      next_cnt = 21'h000000;
      next_done = 1'b1;
    end else if (cnt != 21'h000000) begin
      next_cnt = cnt - 21'h000001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt <= 21'h000000;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end

  assign running = (cnt != 21'h000000);
endmodule : pee_timer

/* File: src/pee_host.sv */
`timescale 1ns/1ps
`include "pee_consts.svh"
// ==========================================
// Host controller for a 2K x 8 parallel byte-write memory
module pee_host #(
  parameter int unsigned LOCKOUT_CYC = `PEE_LOCKOUT_CYC,
  parameter int unsigned WC_CYC = `PEE_WC_STD_CYC,
  parameter int unsigned ERASE_CYC = `PEE_ERASE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // User request
  input wire logic req_valid,
  input wire pee_pkg::pee_req_t req,
  output logic req_ready,
  // User answer
  output logic rsp_valid,
  output pee_pkg::pee_rsp_t rsp,
  // Memory pins
  output pee_pkg::pee_pins_t pins,
  output logic [7:0] data_bus_out,
  output logic data_bus_oe_n,
  input wire logic [7:0] data_bus_in,
  input wire logic ready_busy_n
);
  typedef enum logic [9:0] {
    ST_LOCK = 10'h001,
    ST_IDLE = 10'h002,
    ST_HV = 10'h004,
    ST_RD = 10'h008,
    ST_SETUP = 10'h010,
    ST_PULSE = 10'h020,
    ST_HOLD = 10'h040,
    ST_BUSY = 10'h080,
    ST_POLL = 10'h100,
    ST_FLOAT = 10'h200
  } pee_state_t;

  pee_state_t state;
  pee_state_t next_state;
  pee_pkg::pee_req_t cur;
  pee_pkg::pee_req_t next_cur;
  pee_pkg::pee_pins_t next_pins;
  logic [7:0] next_dout;
  logic next_doe_n;
  logic next_req_ready;
  logic next_rsp_valid;
  pee_pkg::pee_rsp_t next_rsp;
  logic [8:0] cnt;
  logic [8:0] next_cnt;
  logic tmr_load;
  logic [20:0] tmr_count;
  logic tmr_done;
  logic tmr_running;
  logic poll_ok;

  // Long waits: lockout, write time, erase pulse
  pee_timer u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done),
    .running(tmr_running)
  );

  // Completion when polled bit 7 matches the written value
  assign poll_ok = (data_bus_in[`PEE_POLL_BIT] == cur.data[`PEE_POLL_BIT]);

  // ==========================================
  // Sequencer
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_pins = pins;
    next_dout = data_bus_out;
    next_doe_n = data_bus_oe_n;
    next_req_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp = rsp;
    next_cnt = (cnt == 9'h000) ? 9'h000 : cnt - 9'h001;
    tmr_load = 1'b0;
    tmr_count = 21'h000000;
    unique case (state)
      ST_LOCK: begin
        // Wait out the supply lockout before any write
        if (!tmr_running && !tmr_done) begin
          tmr_load = 1'b1;
          tmr_count = 21'(LOCKOUT_CYC);
        end else if (tmr_done) begin
          next_state = ST_IDLE;
          next_req_ready = 1'b1;
        end
      end
      ST_IDLE: begin
        next_req_ready = 1'b1;
        if (req_valid && req_ready) begin
          next_req_ready = 1'b0;
          next_cur = req;
          next_pins.addr_bus = req.addr;
          next_pins.id_area_hv_select = req.id_area;
          next_rsp.timeout = 1'b0;
          next_cnt = 9'(`PEE_HV_CYC);
          next_state = ST_HV;
        end
      end
      ST_HV: begin
        // Clear and id-area accesses let address and high voltage settle before strobes; plain accesses go straight on
        if (cur.cmd == pee_pkg::PEE_CMD_CLEAR) begin
          next_pins.oe_hv = 1'b1;
          next_pins.cs_n = 1'b0;
        end
        if (cnt == 9'h000 || (cur.cmd != pee_pkg::PEE_CMD_CLEAR && !cur.id_area)) begin
          if (cur.cmd == pee_pkg::PEE_CMD_READ) begin
            next_pins.cs_n = 1'b0;
            next_pins.oe_n = 1'b0;
            next_cnt = 9'(`PEE_ACC_CYC);
            next_state = ST_RD;
          end else begin
            next_pins.oe_n = 1'b1;
            next_pins.cs_n = 1'b0;
            next_dout = cur.data;
            next_doe_n = (cur.cmd == pee_pkg::PEE_CMD_CLEAR);
            next_cnt = 9'(`PEE_SETUP_CYC);
            next_state = ST_SETUP;
          end
        end
      end
      ST_RD: begin
        if (cnt == 9'h000) begin
          next_rsp.data = data_bus_in;
          next_rsp_valid = 1'b1;
          next_pins.cs_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_cnt = 9'(`PEE_FLOAT_CYC);
          next_state = ST_FLOAT;
        end
      end
      ST_SETUP: begin
        if (cnt == 9'h000) begin
          next_pins.we_n = 1'b0;
          if (cur.cmd == pee_pkg::PEE_CMD_CLEAR) begin
            tmr_load = 1'b1;
            tmr_count = 21'(ERASE_CYC);
          end
          next_cnt = 9'(`PEE_PULSE_CYC);
          next_state = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if ((cur.cmd == pee_pkg::PEE_CMD_CLEAR) ? tmr_done : (cnt == 9'h000)) begin
          next_pins.we_n = 1'b1;
          // Clear keeps select and high voltage a full settle time past the pulse
          next_cnt = (cur.cmd == pee_pkg::PEE_CMD_CLEAR) ? 9'(`PEE_HV_CYC) : 9'(`PEE_HOLD_CYC);
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt == 9'h000) begin
          next_pins.cs_n = 1'b1;
          next_pins.oe_hv = 1'b0;
          next_doe_n = 1'b1;
          tmr_load = 1'b1;
          tmr_count = 21'(WC_CYC);
          next_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        // Device times itself; host only watches for the end
        if (cur.cmd != pee_pkg::PEE_CMD_CLEAR && ready_busy_n && !tmr_done) begin
          next_pins.cs_n = 1'b0;
          next_pins.oe_n = 1'b0;
          next_cnt = 9'(`PEE_ACC_CYC);
          next_state = ST_POLL;
        end else if (cur.cmd == pee_pkg::PEE_CMD_CLEAR && ready_busy_n) begin
          next_rsp_valid = 1'b1;
          next_state = ST_FLOAT;
        end else if (tmr_done) begin
          next_rsp.timeout = 1'b1;
          next_rsp_valid = 1'b1;
          next_pins.cs_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_state = ST_FLOAT;
        end
      end
      ST_POLL: begin
        if (cnt == 9'h000) begin
          next_pins.cs_n = 1'b1;
          next_pins.oe_n = 1'b1;
          if (poll_ok) begin
            next_rsp.data = data_bus_in;
            next_rsp_valid = 1'b1;
            next_cnt = 9'(`PEE_FLOAT_CYC);
            next_state = ST_FLOAT;
          end else if (tmr_done || !tmr_running) begin
            next_rsp.timeout = 1'b1;
            next_rsp_valid = 1'b1;
            next_cnt = 9'(`PEE_FLOAT_CYC); // Let the polled outputs float first
            next_state = ST_FLOAT;
          end else begin
            next_state = ST_BUSY; // Retry from ST_BUSY at once, with no float wait
          end
        end
      end
      ST_FLOAT: begin
        // No new access until the float count runs out; a timeout from ST_BUSY leaves that count at zero
        next_pins.id_area_hv_select = 1'b0;
        if (cnt == 9'h000) begin
          next_req_ready = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state <= ST_LOCK;
      cur <= '0;
      pins <= '{addr_bus: 11'h000, id_area_hv_select: 1'b0, oe_hv: 1'b0,
                cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      data_bus_out <= 8'h00;
      data_bus_oe_n <= 1'b1;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
      cnt <= 9'h000;
    end else begin
      state <= next_state;
      cur <= next_cur;
      pins <= next_pins;
      data_bus_out <= next_dout;
      data_bus_oe_n <= next_doe_n;
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp <= next_rsp;
      cnt <= next_cnt;
    end
  end
endmodule : pee_host

/* File: test/pee_host_props.sv */
`timescale 1ns/1ps
// ==========================================
// Pin-level checks on the host controller
module pee_host_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // User side
  input wire logic req_valid,
  input wire pee_pkg::pee_req_t req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire pee_pkg::pee_rsp_t rsp,
  // Memory side
  input wire pee_pkg::pee_pins_t pins,
  input wire logic [7:0] data_bus_out,
  input wire logic data_bus_oe_n,
  input wire logic [7:0] data_bus_in,
  input wire logic ready_busy_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Strobe and bus direction relations
  AST_WRITE_OE_HIGH: assert property (!pins.we_n |-> pins.oe_n || pins.oe_hv)
    else $error("write strobe low with output gate low");
  AST_WE_WITH_CS: assert property (!pins.we_n |-> !pins.cs_n)
    else $error("write strobe low without chip select");
  AST_DRIVE_ONLY_WRITE: assert property (!data_bus_oe_n |-> pins.oe_n)
    else $error("host drives data while output gate low");
  AST_ADDR_STABLE: assert property (
    !pins.we_n && !$past(pins.we_n) |-> $stable(pins.addr_bus) && $stable(data_bus_out))
    else $error("address or data moved inside write pulse");
  // Sequencing around the busy line, the answer, lockout, clear pulse and id range
  AST_NO_WRITE_BUSY: assert property ($fell(pins.we_n) |-> ready_busy_n)
    else $error("write pulse started while memory busy");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer strobe longer than one cycle");
  AST_LOCKOUT: assert property ($rose(resetn) |-> !req_ready [*8])
    else $error("request accepted inside power-up lockout");
  AST_WRITE_BOUND: assert property (
    $rose(pins.we_n) && !pins.oe_hv |-> ##[1:1000] rsp_valid)
    else $error("write never answered");
  AST_HV_CLEAR: assert property ($fell(pins.we_n) && pins.oe_hv |-> !pins.we_n [*8])
    else $error("clear pulse too short");
  AST_ID_RANGE: assert property (
    !pins.cs_n && pins.id_area_hv_select |-> pins.addr_bus[10:5] == 6'h3f)
    else $error("id area access outside its address range");
endmodule : pee_host_props

bind pee_host pee_host_props u_props (.clk_sys(clk_sys), .resetn(resetn),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp(rsp), .pins(pins), .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n),
  .data_bus_in(data_bus_in), .ready_busy_n(ready_busy_n));

/* File: test/pee_mem_model.sv */
`timescale 1ns/1ps
// ==========================================
// Behavioural byte-write memory, sampled on the system clock
module pee_mem_model #(
  parameter int BUSY_CYC = 100,
  parameter int LOCK_CYC = 20,
  parameter int CLEAR_CYC = 50
) (
  // Clock and fault control
  input wire logic clk_sys,
  input wire logic slow,
  // Pins
  input wire pee_pkg::pee_pins_t pins,
  input wire logic [7:0] bus_wr,
  output logic [7:0] bus_rd,
  output logic ready_busy_n
);
  logic [7:0] mem [0:2047];
  logic [7:0] id_mem [0:31];
  logic [7:0] wdat, last;
  logic [10:0] wadr;
  logic wid, strb_q, strb, rd_en;
  int busy, lock, low_cnt;
  assign strb = pins.cs_n | pins.we_n;
  assign rd_en = !pins.cs_n && !pins.oe_n && pins.we_n;
  assign ready_busy_n = (busy == 0);
  // Known contents so reads are meaningful
  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 8'h00;
    for (int i = 0; i < 32; i++) id_mem[i] = 8'h00;
    busy = 0;
    lock = LOCK_CYC;
    low_cnt = 0;
    strb_q = 1'b1;
    last = 8'h00;
  end
  // Latches, self-timed program, and clear on a long enough high-voltage pulse
  always @(posedge clk_sys) begin
    strb_q <= strb;
    last <= bus_rd;
    if (busy > 0) busy <= busy - 1;
    if (lock > 0) lock <= lock - 1;
    low_cnt <= (!strb && pins.oe_hv) ? low_cnt + 1 : 0;
    if (busy == 1 && wid) id_mem[wadr[4:0]] <= wdat;
    if (busy == 1 && !wid) mem[wadr] <= wdat;
    if (strb_q && !strb && busy == 0 && lock == 0) begin
      wadr <= pins.addr_bus;
      wid <= pins.id_area_hv_select;
    end
    if (!strb_q && strb && pins.oe_n && !pins.oe_hv && busy == 0 && lock == 0) begin
      wdat <= bus_wr;
      busy <= slow ? 1000 : BUSY_CYC;
    end
    if (!strb_q && strb && pins.oe_hv && low_cnt >= CLEAR_CYC && lock == 0) begin
      for (int i = 0; i < 2048; i++) mem[i] <= 8'hff;
    end
  end
  // Floating bus shows a changing pattern, no pull
  always_comb begin
    if (!rd_en) bus_rd = ~last;
    else if (busy > 0) bus_rd = {~wdat[7], 7'h2a};
    else if (pins.id_area_hv_select) bus_rd = id_mem[pins.addr_bus[4:0]];
    else bus_rd = mem[pins.addr_bus];
  end
endmodule : pee_mem_model

/* File: test/testbench.sv */
`timescale 1ns/1ps
// ==========================================
// Host controller against the memory model
module testbench;
  logic clk_sys, resetn, req_valid, req_ready, rsp_valid, ready_busy_n;
  logic data_bus_oe_n, slow;
  pee_pkg::pee_req_t req;
  pee_pkg::pee_rsp_t rsp;
  pee_pkg::pee_pins_t pins;
  logic [7:0] data_bus_out, mem_rd, bus_wire;
  int failures, compares, cycles, n;
  // Wire level from both drivers
  assign bus_wire = data_bus_oe_n ? mem_rd : data_bus_out;
  pee_host #(.LOCKOUT_CYC(10), .WC_CYC(300), .ERASE_CYC(50)) u_dut (.clk_sys(clk_sys),
    .resetn(resetn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .data_bus_out(data_bus_out),
    .data_bus_oe_n(data_bus_oe_n), .data_bus_in(bus_wire), .ready_busy_n(ready_busy_n));
  pee_mem_model u_mem (.clk_sys(clk_sys), .slow(slow), .pins(pins), .bus_wr(bus_wire),
    .bus_rd(mem_rd), .ready_busy_n(ready_busy_n));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Watchdog, run needs a few thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("unexpected cycles expected below 20000 seen %0d", cycles);
      complete_run();
    end
  end
  task automatic complete_run;
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // One request, waits bounded; n holds the answer latency
  task automatic op(pee_pkg::pee_cmd_t c, logic id, logic [10:0] a, logic [7:0] d);
    n = 0;
    while (req_ready !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    check("req_ready", 8'h01, {7'h0, req_ready});
    req <= '{cmd: c, id_area: id, addr: a, data: d};
    req_valid <= 1'b1;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    check("rsp_valid", 8'h01, {7'h0, rsp_valid});
  endtask : op
  task automatic t_lockout;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    check("lockout", 8'h01, {7'h0, n >= 10});
    check("lockout_end", 8'h01, {7'h0, req_ready});
  endtask : t_lockout
  // Both polarities of the polled bit, top address
  task automatic t_write_read;
    logic [7:0] v [2] = '{8'h80, 8'h7f};
    for (int i = 0; i < 2; i++) begin
      op(pee_pkg::PEE_CMD_WRITE, 1'b0, 11'h7ff, v[i]);
      check("write_wait", 8'h01, {7'h0, n >= 100});
      check("write_to", 8'h00, {7'h0, rsp.timeout});
      op(pee_pkg::PEE_CMD_READ, 1'b0, 11'h7ff, 8'h00);
      check("read", v[i], rsp.data);
    end
  endtask : t_write_read
  task automatic t_id_area;
    op(pee_pkg::PEE_CMD_WRITE, 1'b1, 11'h7e5, 8'h3c);
    op(pee_pkg::PEE_CMD_READ, 1'b0, 11'h7e5, 8'h00);
    check("main_7e5", 8'h00, rsp.data);
    op(pee_pkg::PEE_CMD_READ, 1'b1, 11'h7e5, 8'h00);
    check("id_7e5", 8'h3c, rsp.data);
  endtask : t_id_area
  task automatic t_clear;
    op(pee_pkg::PEE_CMD_CLEAR, 1'b0, 11'h000, 8'h00);
    op(pee_pkg::PEE_CMD_READ, 1'b0, 11'h123, 8'h00);
    check("clear_123", 8'hff, rsp.data);
    op(pee_pkg::PEE_CMD_READ, 1'b0, 11'h7ff, 8'h00);
    check("clear_7ff", 8'hff, rsp.data);
  endtask : t_clear
  // Memory stays busy past the write time
  task automatic t_timeout;
    slow <= 1'b1;
    op(pee_pkg::PEE_CMD_WRITE, 1'b0, 11'h010, 8'h10);
    check("timeout", 8'h01, {7'h0, rsp.timeout});
    slow <= 1'b0;
    n = 0;
    while (ready_busy_n !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    check("busy_end", 8'h01, {7'h0, ready_busy_n});
    // The late write still lands once the memory releases the line
    op(pee_pkg::PEE_CMD_READ, 1'b0, 11'h010, 8'h00);
    check("late_write", 8'h10, rsp.data);
  endtask : t_timeout
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b0;
    failures = 0;
    compares = 0;
    cycles = 0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    t_lockout();
    t_write_read();
    t_id_area();
    t_clear();
    t_timeout();
    complete_run();
  end
endmodule : testbench
